/* logic/safe_link_pkg.sv */
// shared constants and types for the safe link between controller and module
// assumes a single 50 MHz clock on both ends
package safe_link_pkg;
    // ==========================================================
    // clocking and watchdog timing
    localparam int unsigned CLK_HZ         = 50000000;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned WDOG_MIN_MS    = 10;
    localparam int unsigned WDOG_MAX_MS    = 10000;
    localparam logic [13:0] WDOG_RST_MS    = 14'h0064;
    // ==========================================================
    // address limits
    localparam logic [7:0]  ADDR_NONE      = 8'h00;
    localparam logic [7:0]  ADDR_ALL_ONES  = 8'hff;
    // ==========================================================
    // telegram kinds on the link
    localparam logic [1:0]  KIND_PARAM     = 2'h0;
    localparam logic [1:0]  KIND_DATA      = 2'h1;
    localparam logic [1:0]  KIND_RESET     = 2'h2;
    // ==========================================================
    // drive profile bit positions and reset values
    localparam int unsigned TORQUE_OFF_BIT = 0;
    localparam logic [7:0]  CTRL_RST_VAL   = 8'h00;
    localparam logic [31:0] OUT_RST_VAL    = 32'h00000000;
    // connection states shared by both ends
    typedef enum logic [3:0] {
        CONN_RESET = 4'b0001,
        CONN_PARAM = 4'b0010,
        CONN_DATA  = 4'b0100,
        CONN_FAIL  = 4'b1000
    } conn_type;
endpackage : safe_link_pkg

/* logic/safe_link_if.sv */
// interface joining controller end and module end of the safe link
// assumes both ends share CORE_CLK
`timescale 1ns/10ps
interface safe_link_if;
    // request telegram, controller to module
    logic        req_valid;
    logic [1:0]  req_kind;
    logic [15:0] req_link_id;
    logic [7:0]  req_addr;
    logic [13:0] req_wdog_ms;
    logic [31:0] req_data;
    logic [7:0]  req_ctrl;
    // acknowledgement telegram, module to controller
    logic        ack_valid;
    logic [1:0]  ack_kind;
    logic [15:0] ack_link_id;
    logic [31:0] ack_data;
    logic [7:0]  ack_status;
    modport controller (
        output req_valid, req_kind, req_link_id, req_addr, req_wdog_ms,
        output req_data, req_ctrl,
        input  ack_valid, ack_kind, ack_link_id, ack_data, ack_status
    );
    modport module_end (
        input  req_valid, req_kind, req_link_id, req_addr, req_wdog_ms,
        input  req_data, req_ctrl,
        output ack_valid, ack_kind, ack_link_id, ack_data, ack_status
    );
endinterface : safe_link_if

/* logic/wdog_timer.sv */
// watchdog timer counting milliseconds from a tick divider
// assumes a 50 MHz clock and a timeout given in ms
`timescale 1ns/10ps
module wdog_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [13:0] limit_ms,
    // status
    output logic             expired
);
    typedef struct packed {
        logic [15:0] div;
        logic [13:0] ms;
        logic        run;
        logic        exp;
    } st_type;
    st_type s_q, s_d;
    logic   tick;

    // ==========================================================
    // next state
    always_comb begin
        s_d  = s_q;
        tick = (s_q.div == 16'(safe_link_pkg::CYC_PER_MS - 1));
        if (s_q.run) begin
            s_d.div = tick ? 16'h0000 : s_q.div + 16'h0001;
            if (tick) begin
                s_d.ms = s_q.ms + 14'h0001;
            end
            if (tick && (s_q.ms + 14'h0001 >= limit_ms)) begin
                s_d.exp = 1'b1;
                s_d.run = 1'b0;
            end
        end
        // restart wins over stop
        if (stop) begin
            s_d.run = 1'b0;
        end
        if (start) begin
            s_d.run = 1'b1;
            s_d.div = 16'h0000;
            s_d.ms  = 14'h0000;
            s_d.exp = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // a restart in progress masks the stale expiry of the last run
    assign expired = s_q.exp && !start;
endmodule : wdog_timer

/* logic/safe_module_end.sv */
// module end of the safe link: answers requests, supervises the link
// assumes controller end on safe_link_if, switches static while booting
// Notes on behaviour
// - controller sends request, starts its watchdog
// - module acknowledges request and starts watchdog
// - controller stops watchdog, then next request
// - watchdog expiry: reset state, safe state
// - timeout outside 10..10000 ms is error
// - controller delivers address and watchdog time
// - address is weighted sum of switches
// - only addresses 1 to 254 valid
// - each address used by one module only
// - switches sampled once after boot
// - link identifier unique per connection
// - data exchange only in data state
// - reset telegram ends the exchange
// - latch received inputs at cycle start
// - hand outputs over after cycle ends
// - 32 safe inputs, 32 safe outputs
// - control bit 0 torque off, status mirrors
// - controller holds torque off bit at 1 (here bit 0 follows TORQUE_OFF_REQ)
// - input 0 activates, 1 deactivates function
// - deactivated function reports output 0
`timescale 1ns/10ps
module safe_module_end (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // link to controller
    safe_link_if.module_end  LINK,
    // address switches and own link identifier
    input  wire logic [7:0]  ADDR_SW,
    input  wire logic [15:0] LINK_ID,
    // user side: safety function status and results
    input  wire logic [31:0] FUNC_STATUS,
    // user side: outputs to safety logic
    output logic [31:0] FUNC_ACTIVE,
    output logic        TORQUE_OFF,
    output logic        SAFE_STATE,
    output logic        MODULE_ERROR,
    output logic        IN_DATA,
    output logic [7:0]  MODULE_ADDR
);
    typedef struct packed {
        // connection state and boot capture
        safe_link_pkg::conn_type conn;
        logic        booted;
        logic [7:0]  addr;
        logic        addr_ok;
        logic [13:0] wdog_ms;
        logic        err;
        // latched request and pending answer
        logic [31:0] in_lat;
        logic        torque;
        logic        cyc;
        logic        ack_v;
        logic [1:0]  ack_k;
        logic [31:0] ack_d;
        logic [7:0]  ack_s;
        logic        wd_start;
        // registered copies behind the top outputs
        logic        safe;
        logic        in_dat;
        logic [15:0] ack_id;
    } st_type;
    // registered state and its next value
    st_type s_q, s_d;
    logic   wd_exp;
    logic   req_ok;
    logic   cfg_ok;

    // ==========================================================
    // watchdog on arrival of the next telegram
    wdog_timer u_wdog (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .start    (s_q.wd_start),
        .stop     (1'b0),
        .limit_ms (s_q.wdog_ms),
        .expired  (wd_exp)
    );

    // ==========================================================
    // link state machine and data path
    always_comb begin
        s_d          = s_q;
        s_d.ack_v    = 1'b0;
        s_d.wd_start = 1'b0;
        s_d.cyc      = 1'b0;

        // telegram meant for this connection
        req_ok = LINK.req_valid && (LINK.req_link_id == LINK_ID);
        // watchdog time inside the accepted range
        cfg_ok = (LINK.req_wdog_ms >= 14'(safe_link_pkg::WDOG_MIN_MS))
              && (LINK.req_wdog_ms <= 14'(safe_link_pkg::WDOG_MAX_MS));

        // catch switches once after reset release
        if (!s_q.booted) begin
            s_d.booted  = 1'b1;
            s_d.addr    = ADDR_SW;
            s_d.addr_ok = (ADDR_SW != safe_link_pkg::ADDR_NONE)
                       && (ADDR_SW != safe_link_pkg::ADDR_ALL_ONES);
        end

        unique case (s_q.conn)
            // parameter telegram opens the connection
            safe_link_pkg::CONN_RESET: begin
                if (req_ok && s_q.addr_ok
                    && LINK.req_kind == safe_link_pkg::KIND_PARAM
                    && LINK.req_addr == s_q.addr) begin
                    if (cfg_ok) begin
                        s_d.wdog_ms = LINK.req_wdog_ms;
                        s_d.conn    = safe_link_pkg::CONN_PARAM;
                        s_d.ack_v   = 1'b1;
                        s_d.ack_k   = safe_link_pkg::KIND_PARAM;
                        s_d.wd_start = 1'b1;
                    end else begin
                        // out of range: error until the next reset
                        s_d.err  = 1'b1;
                        s_d.conn = safe_link_pkg::CONN_FAIL;
                    end
                end
            end

            safe_link_pkg::CONN_PARAM, safe_link_pkg::CONN_DATA: begin
                // expiry first: a late telegram no longer counts
                if (wd_exp) begin
                    s_d.conn = safe_link_pkg::CONN_RESET;
                end else if (req_ok
                    && LINK.req_kind == safe_link_pkg::KIND_RESET) begin
                    s_d.conn = safe_link_pkg::CONN_RESET;
                end else if (req_ok
                    && LINK.req_kind == safe_link_pkg::KIND_DATA) begin
                    s_d.conn     = safe_link_pkg::CONN_DATA;
                    s_d.in_lat   = LINK.req_data;
                    s_d.torque   =
                        ~LINK.req_ctrl[safe_link_pkg::TORQUE_OFF_BIT];
                    s_d.cyc      = 1'b1;
                    s_d.wd_start = 1'b1;
                end
            end

            // only a new reset leaves the error state
            safe_link_pkg::CONN_FAIL: begin
                s_d.conn = safe_link_pkg::CONN_FAIL;
            end

            // illegal code falls back to reset
            default: begin
                s_d.conn = safe_link_pkg::CONN_RESET;
            end
        endcase

        // answer one cycle after the inputs were latched
        if (s_q.cyc) begin
            s_d.ack_v = 1'b1;
            s_d.ack_k = safe_link_pkg::KIND_DATA;
            // outputs of deactivated functions forced to 0
            s_d.ack_d = FUNC_STATUS & ~s_q.in_lat;
            s_d.ack_s = {7'h00, s_q.torque};
        end

        // leaving data state drops to safe values
        if (s_d.conn != safe_link_pkg::CONN_DATA) begin
            s_d.in_lat = 32'h00000000;
            s_d.torque = 1'b1;
        end

        // output flags follow the next state, so they come from flops
        s_d.safe   = (s_d.conn != safe_link_pkg::CONN_DATA);
        s_d.in_dat = (s_d.conn == safe_link_pkg::CONN_DATA);
        s_d.ack_id = LINK_ID;
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            // safe values while reset is held
            s_q         <= '0;
            s_q.conn    <= safe_link_pkg::CONN_RESET;
            s_q.wdog_ms <= safe_link_pkg::WDOG_RST_MS;
            s_q.torque  <= 1'b1;
            s_q.safe    <= 1'b1;
            s_q.ack_k   <= safe_link_pkg::KIND_PARAM;
            s_q.ack_d   <= safe_link_pkg::OUT_RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // telegram outputs, all from flip-flops
    assign LINK.ack_valid   = s_q.ack_v;
    assign LINK.ack_kind    = s_q.ack_k;
    assign LINK.ack_link_id = s_q.ack_id;
    assign LINK.ack_data    = s_q.ack_d;
    assign LINK.ack_status  = s_q.ack_s;

    // user side outputs
    assign FUNC_ACTIVE      = ~s_q.in_lat;
    assign TORQUE_OFF       = s_q.torque;
    assign SAFE_STATE       = s_q.safe;
    assign MODULE_ERROR     = s_q.err;
    assign IN_DATA          = s_q.in_dat;
    assign MODULE_ADDR      = s_q.addr;
endmodule : safe_module_end

/* logic/safe_ctrl_end.sv */
// controller end of the safe link: opens cycles, supervises answers
// assumes module end on safe_link_if, user holds settings steady
`timescale 1ns/10ps
module safe_ctrl_end (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // link to module
    safe_link_if.controller  LINK,
    // user side: connection settings
    input  wire logic        ENABLE,
    input  wire logic [15:0] LINK_ID,
    input  wire logic [7:0]  TARGET_ADDR,
    input  wire logic [13:0] WDOG_MS,
    // user side: cyclic data
    input  wire logic [31:0] OUT_DATA,
    input  wire logic        TORQUE_OFF_REQ,
    output logic [31:0] IN_DATA,
    output logic [7:0]  IN_STATUS,
    output logic        IN_VALID,
    output logic        SAFE_STATE,
    output logic        CONNECTED
);
    typedef struct packed {
        safe_link_pkg::conn_type conn;
        logic        wait_ack;
        logic        req_v;
        logic [1:0]  req_k;
        logic [31:0] req_d;
        logic [7:0]  req_c;
        logic [31:0] in_d;
        logic [7:0]  in_s;
        logic        in_v;
        logic        wd_start;
        logic        wd_stop;
    } st_type;
    st_type s_q, s_d;
    logic   wd_exp;
    logic   ack_ok;

    // ==========================================================
    // watchdog on the answer
    wdog_timer u_wdog (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .start    (s_q.wd_start),
        .stop     (s_q.wd_stop),
        .limit_ms (WDOG_MS),
        .expired  (wd_exp)
    );

    // ==========================================================
    // request sequencing
    always_comb begin
        s_d          = s_q;
        s_d.req_v    = 1'b0;
        s_d.in_v     = 1'b0;
        s_d.wd_start = 1'b0;
        s_d.wd_stop  = 1'b0;
        ack_ok = LINK.ack_valid && (LINK.ack_link_id == LINK_ID);
        if (!s_q.wait_ack && ENABLE && !s_q.req_v
            && s_q.conn != safe_link_pkg::CONN_FAIL) begin
            s_d.req_v    = 1'b1;
            s_d.wd_start = 1'b1;
            s_d.wait_ack = 1'b1;
            s_d.req_k    = (s_q.conn == safe_link_pkg::CONN_RESET)
                         ? safe_link_pkg::KIND_PARAM
                         : safe_link_pkg::KIND_DATA;
            s_d.req_d    = OUT_DATA;
            s_d.req_c    = {7'h00, TORQUE_OFF_REQ};
        end else if (!ENABLE && s_q.conn != safe_link_pkg::CONN_RESET
            && !s_q.wait_ack) begin
            s_d.req_v = 1'b1;
            s_d.req_k = safe_link_pkg::KIND_RESET;
            s_d.conn  = safe_link_pkg::CONN_RESET;
        end
        if (s_q.wait_ack && wd_exp) begin
            s_d.wait_ack = 1'b0;
            s_d.conn     = safe_link_pkg::CONN_RESET;
        end else if (s_q.wait_ack && ack_ok) begin
            s_d.wait_ack = 1'b0;
            s_d.wd_stop  = 1'b1;
            s_d.conn     = safe_link_pkg::CONN_DATA;
            if (LINK.ack_kind == safe_link_pkg::KIND_DATA) begin
                s_d.in_d = LINK.ack_data;
                s_d.in_s = LINK.ack_status;
                s_d.in_v = 1'b1;
            end
        end
        if (s_d.conn != safe_link_pkg::CONN_DATA) begin
            s_d.in_d = 32'h00000000;
        end
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q      <= '0;
            s_q.conn <= safe_link_pkg::CONN_RESET;
            s_q.req_k <= safe_link_pkg::KIND_PARAM;
            s_q.req_c <= safe_link_pkg::CTRL_RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign LINK.req_valid   = s_q.req_v;
    assign LINK.req_kind    = s_q.req_k;
    assign LINK.req_link_id = LINK_ID;
    assign LINK.req_addr    = TARGET_ADDR;
    assign LINK.req_wdog_ms = WDOG_MS;
    assign LINK.req_data    = s_q.req_d;
    assign LINK.req_ctrl    = s_q.req_c;
    assign IN_DATA          = s_q.in_d;
    assign IN_STATUS        = s_q.in_s;
    assign IN_VALID         = s_q.in_v;
    assign SAFE_STATE       = (s_q.conn != safe_link_pkg::CONN_DATA);
    assign CONNECTED        = (s_q.conn == safe_link_pkg::CONN_DATA);
endmodule : safe_ctrl_end

/* verification/safe_link_properties.sv */
// checker of the telegram wire between controller end and module end
// assumes instantiation beside safe_link_if on the shared core clock
`timescale 1ns/10ps
module safe_link_properties (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    // request telegram
    input wire logic        req_valid,
    input wire logic [1:0]  req_kind,
    input wire logic [15:0] req_link_id,
    input wire logic [7:0]  req_addr,
    input wire logic [13:0] req_wdog_ms,
    input wire logic [31:0] req_data,
    input wire logic [7:0]  req_ctrl,
    // acknowledgement telegram
    input wire logic        ack_valid,
    input wire logic [1:0]  ack_kind,
    input wire logic [15:0] ack_link_id,
    input wire logic [31:0] ack_data,
    input wire logic [7:0]  ack_status
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // ==========================================
    // decoded telegram conditions
    wire logic param_req = req_valid && req_kind == safe_link_pkg::KIND_PARAM;
    wire logic data_ack  = ack_valid && ack_kind == safe_link_pkg::KIND_DATA;
    wire logic wd_bad    = 32'(req_wdog_ms) < safe_link_pkg::WDOG_MIN_MS
                           || 32'(req_wdog_ms) > safe_link_pkg::WDOG_MAX_MS;
    wire logic addr_bad  = req_addr == safe_link_pkg::ADDR_NONE
                           || req_addr == safe_link_pkg::ADDR_ALL_ONES;
    wire logic ctl_bit   = req_ctrl[safe_link_pkg::TORQUE_OFF_BIT];
    // ==========================================
    // answer timing and content
    a_ack_pulse: assert property (ack_valid |=> !ack_valid)
        else $error("ack_valid held too long");
    a_ack_cause: assert property (ack_valid |->
        $past(req_valid) || $past(req_valid, 2))
        else $error("ack without request");
    a_param_next: assert property (ack_valid &&
        ack_kind == safe_link_pkg::KIND_PARAM |-> $past(param_req))
        else $error("param ack not one cycle after param request");
    a_data_late: assert property (data_ack |-> $past(req_valid, 2)
        && $past(req_kind, 2) == safe_link_pkg::KIND_DATA)
        else $error("data ack not two cycles after data request");
    a_reset_quiet: assert property (req_valid &&
        req_kind == safe_link_pkg::KIND_RESET |=> !ack_valid [*2])
        else $error("reset telegram answered");
    a_addr_refused: assert property (param_req && addr_bad |=>
        !ack_valid) else $error("bad address answered");
    a_wdog_refused: assert property (param_req && wd_bad |=>
        !ack_valid) else $error("bad watchdog time answered");
    a_torque_mirror: assert property (data_ack |->
        ack_status[0] == !$past(ctl_bit, 2))
        else $error("status bit0 not torque off");
    a_off_zero: assert property (data_ack |->
        (ack_data & $past(req_data, 2)) == 32'h00000000)
        else $error("deactivated output not zero");
    a_link_match: assert property (ack_valid |->
        ack_link_id == req_link_id) else $error("ack link id differs");
    // main scenarios reached
    c_param: cover property (param_req ##1 ack_valid);
    c_data: cover property (data_ack);
    c_reset: cover property (req_valid
        && req_kind == safe_link_pkg::KIND_RESET);
endmodule : safe_link_properties

/* verification/testbench.sv */
// self-checking bench joining controller end and module end
// assumes both design ends and safe_link_if compiled before it
`timescale 1ns/10ps
module testbench;
    // stimulus and observed signals
    logic        core_clk, rst_n, enable, torque_req, torque_off;
    logic        mod_safe, mod_err, mod_data, c_valid, c_conn, c_safe;
    logic [15:0] ctrl_id, mod_id;
    logic [7:0]  target_addr, addr_sw, mod_addr, c_status, boot_sw;
    logic [13:0] wdog_ms;
    logic [31:0] out_data, func_status, func_active, c_in_data;
    int          n_mismatch, num_checks;
    // connection cases: switches, watchdog ms, id ok, connects, error
    logic [7:0]  sw_t [7] = '{8'h01, 8'hfe, 8'h00, 8'hff, 8'h0a,
                              8'h0a, 8'h0a};
    logic [13:0] wd_t [7] = '{14'h000a, 14'h2710, 14'h000a, 14'h000a,
                              14'h0009, 14'h2711, 14'h000a};
    logic        id_t [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
    logic        cn_t [7] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
    logic        er_t [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    // ==========================================
    // design ends, wire and checker
    safe_link_if link ();
    safe_ctrl_end u_safe_ctrl_end (.CORE_CLK(core_clk), .RST_N(rst_n),
        .LINK(link), .ENABLE(enable), .LINK_ID(ctrl_id),
        .TARGET_ADDR(target_addr), .WDOG_MS(wdog_ms), .OUT_DATA(out_data),
        .TORQUE_OFF_REQ(torque_req), .IN_DATA(c_in_data),
        .IN_STATUS(c_status), .IN_VALID(c_valid), .SAFE_STATE(c_safe),
        .CONNECTED(c_conn));
    safe_module_end u_safe_module_end (.CORE_CLK(core_clk), .RST_N(rst_n),
        .LINK(link), .ADDR_SW(addr_sw), .LINK_ID(mod_id),
        .FUNC_STATUS(func_status), .FUNC_ACTIVE(func_active),
        .TORQUE_OFF(torque_off), .SAFE_STATE(mod_safe),
        .MODULE_ERROR(mod_err), .IN_DATA(mod_data), .MODULE_ADDR(mod_addr));
    safe_link_properties u_safe_link_properties (.CORE_CLK(core_clk),
        .RST_N(rst_n), .req_valid(link.req_valid), .req_kind(link.req_kind),
        .req_link_id(link.req_link_id), .req_addr(link.req_addr),
        .req_wdog_ms(link.req_wdog_ms), .req_data(link.req_data),
        .req_ctrl(link.req_ctrl), .ack_valid(link.ack_valid),
        .ack_kind(link.ack_kind), .ack_link_id(link.ack_link_id),
        .ack_data(link.ack_data), .ack_status(link.ack_status));
    // ==========================================
    // helpers
    function automatic logic [31:0] exp_in(logic [31:0] fs, logic [31:0] od);
        return fs & ~od;
    endfunction : exp_in
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // reset for 20 cycles, enable, wait for data state or give up
    task automatic boot(logic [7:0] sw, logic idok, logic [13:0] wd);
        rst_n = 0;
        enable = 0;
        addr_sw = sw;
        target_addr = sw;
        ctrl_id = idok ? mod_id : ~mod_id;
        wdog_ms = wd;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1;
        repeat (2) @(posedge core_clk);
        #1 enable = 1;
        for (int k = 0; k < 300 && mod_data !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
    endtask : boot
    // wait for the next answer at the controller user side
    task automatic wait_valid();
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while (c_valid !== 1'b1 && k < 50);
        check("in_valid", 32'h1, {31'h0, c_valid});
    endtask : wait_valid
    // ==========================================
    // clock and watchdog
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        stop_test();
    end
    // ==========================================
    // main sequence
    initial begin
        {rst_n, enable, out_data, func_status, addr_sw} = '0;
        {target_addr, wdog_ms, ctrl_id} = '0;
        torque_req = 1;
        mod_id = 16'h3c5a;
        void'($urandom(32'h73351c2c));
        @(posedge core_clk);
        #1;
        // limits of address, watchdog time and link identifier
        for (int i = 0; i < 7; i++) begin
            boot(sw_t[i], id_t[i], wd_t[i]);
            check("mod in_data", 32'(cn_t[i]), 32'(mod_data));
            check("connected", 32'(cn_t[i]), 32'(c_conn));
            check("mod error", 32'(er_t[i]), 32'(mod_err));
            check("mod safe", 32'(!cn_t[i]), 32'(mod_safe));
            check("ctrl safe", 32'(!cn_t[i]), 32'(c_safe));
        end
        // random address, then cyclic data
        boot_sw = 8'($urandom_range(254, 1));
        boot(boot_sw, 1'h1, 14'h000a);
        check("mod addr", 32'(boot_sw), 32'(mod_addr));
        addr_sw = ~boot_sw;
        for (int i = 0; i < 12; i++) begin
            out_data = i == 0 ? 32'h0 : i == 1 ? 32'hffffffff : $urandom;
            func_status = $urandom;
            torque_req = i < 2 ? 1'b1 : 1'($urandom);
            wait_valid();
            wait_valid();
            check("ctrl data", exp_in(func_status, out_data),
                  c_in_data);
            check("active", ~out_data, func_active);
            check("status0", 32'(!torque_req), 32'(c_status[0]));
            check("torque", 32'(!torque_req), 32'(torque_off));
        end
        check("addr held", 32'(boot_sw), 32'(mod_addr));
        // controller leaves: reset telegram ends the exchange
        enable = 0;
        for (int k = 0; k < 50 && mod_data !== 1'b0; k++) begin
            @(posedge core_clk);
            #1;
        end
        check("mod left", 32'h0, 32'(mod_data));
        check("safe state", 32'h1, 32'(mod_safe));
        check("ctrl safe", 32'h1, 32'(c_safe));
        check("torque left", 32'h1, 32'(torque_off));
        check("active left", 32'hffffffff, func_active);
        stop_test();
    end
endmodule : testbench
